// File: phrf_pkg.sv
package phrf_pkg;
  // register map, word index on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SLOPE  = 4'h1;
  localparam logic [3:0] REG_TRANS  = 4'h2;
  localparam logic [3:0] REG_RESP   = 4'h3;
  localparam logic [3:0] REG_CLEAR  = 4'h4;
  localparam logic [3:0] REG_LOWLIM = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_TEMP   = 4'h7;
  localparam logic [3:0] REG_PEAK0  = 4'h8;
  localparam logic [3:0] REG_PEAK1  = 4'h9;

  // settings in thousandths, low limit in tenths of a degree
  localparam logic [15:0] SLOPE_MIN   = 16'h0320;
  localparam logic [15:0] SLOPE_MAX   = 16'h04B0;
  localparam logic [15:0] SLOPE_RST   = 16'h03E8;
  localparam logic [15:0] TRANS_MIN   = 16'h0032;
  localparam logic [15:0] TRANS_MAX   = 16'h03E8;
  localparam logic [15:0] TRANS_RST   = 16'h03E8;
  localparam logic [31:0] SCALE_MILLI = 32'h0000_03E8;
  localparam logic [15:0] LOWLIM_RST  = 16'h0000;

  // response time selector
  localparam logic [2:0] RESP_MIN  = 3'h0;
  localparam logic [2:0] RESP_10MS = 3'h1;
  localparam logic [2:0] RESP_10S  = 3'h6;

  // peak clear selector
  localparam logic [3:0] CLR_OFF    = 4'h0;
  localparam logic [3:0] CLR_IVL_LO = 4'h1;
  localparam logic [3:0] CLR_IVL_HI = 4'h6;
  localparam logic [3:0] CLR_EXTERN = 4'h7;
  localparam logic [3:0] CLR_AUTO   = 4'h8;
  localparam logic [3:0] CLR_HOLD   = 4'h9;

  // sample period
  localparam int SAMPLE_PERIOD_NS = 10_000_000;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W     = 20;

  // auto clear margin, temperature in tenths of a degree
  localparam logic [16:0] AUTO_MIN_RISE = 17'h00014;
  localparam logic [16:0] AUTO_PCT_DIV  = 17'h00064;
  localparam int          FRAC_W        = 8;

  // smoothing shift per response setting, 90 % near the chosen time
  function automatic logic [3:0] resp_shift(input logic [2:0] sel);
    case (sel)
      3'h2:    resp_shift = 4'h1;
      3'h3:    resp_shift = 4'h3;
      3'h4:    resp_shift = 4'h5;
      3'h5:    resp_shift = 4'h7;
      3'h6:    resp_shift = 4'h9;
      default: resp_shift = 4'h0;
    endcase
  endfunction

  // clear interval in sample periods
  function automatic logic [11:0] ivl_ticks(input logic [3:0] sel);
    case (sel)
      4'h2:    ivl_ticks = 12'h005;
      4'h3:    ivl_ticks = 12'h019;
      4'h4:    ivl_ticks = 12'h064;
      4'h5:    ivl_ticks = 12'h1F4;
      4'h6:    ivl_ticks = 12'h9C4;
      default: ivl_ticks = 12'h001;
    endcase
  endfunction
endpackage

// File: phrf_div_if.sv
`timescale 1ns/100ps
interface phrf_div_if;
  logic        req;
  logic [31:0] num;
  logic [15:0] den;
  logic        busy;
  logic        done;
  logic [15:0] quo;
  modport ctrl (output req, num, den, input busy, done, quo);
  modport unit (input req, num, den, output busy, done, quo);
endinterface

// File: phrf_sync.sv
`timescale 1ns/100ps
module phrf_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // pin and filtered level
  input  wire logic i_async,
  output logic      o_level
);
  logic ff1;
  logic ff2;
  logic ff3;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
    end else begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level <= 1'b0;
    end else if (ff2 == ff3) begin
      o_level <= ff3;
    end
  end
endmodule

// File: phrf_div.sv
`timescale 1ns/100ps
module phrf_div
  import phrf_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // request and result
  phrf_div_if.unit  div
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_DONE = 3'b100
  } phrf_div_state_t;

  phrf_div_state_t state;
  logic [16:0]     rem;
  logic [31:0]     q;
  logic [15:0]     den;
  logic [5:0]      cnt;
  logic [16:0]     sh;

  assign sh = {rem[15:0], q[31]};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= S_IDLE;
      rem   <= 17'h00000;
      q     <= 32'h0000_0000;
      den   <= 16'h0001;
      cnt   <= 6'h00;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (div.req) begin
            state <= S_RUN;
            rem   <= 17'h00000;
            q     <= div.num;
            den   <= div.den;
            cnt   <= 6'h00;
          end
        end
        S_RUN: begin
          // restoring step, one quotient bit per cycle
          if (sh >= {1'b0, den}) begin
            rem <= sh - {1'b0, den};
            q   <= {q[30:0], 1'b1};
          end else begin
            rem <= sh;
            q   <= {q[30:0], 1'b0};
          end
          cnt <= cnt + 6'h01;
          if (cnt == 6'h1F) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign div.busy = (state != S_IDLE);
  assign div.done = (state == S_DONE);
  // saturate a quotient beyond 16 bits
  assign div.quo  = (q[31:16] != 16'h0000) ? 16'hFFFF : q[15:0];
endmodule

// File: phrf_top.sv
// Contract
// - two-colour mode takes slope 0.800 to 1.200 in thousandths, corrects ratio
// - slope is first over second emissivity; ratio divided by it first
// - one-colour mode takes transmittance 5 % to 100 % in thousandths
// - new measurement and output refresh every 10 ms, any response setting
// - step rise reaches 90 % after the selected response time
// - response choices: min, 0.01, 0.05, 0.25, 1, 3, 10 s
// - min choice: time constant under 2 ms, faster adaption at low signal; code smooths with shift 1 at low signal, shift 0 otherwise
// - clear choices: off, six intervals, extern, auto, hold
// - peak storage on for every clear choice except off and hold
// - enabled storage keeps and shows highest value since last clear
// - single storage: one contact pulse clears, then new maximum builds
// - auto clearing uses a single store
// - any timed interval uses two peak stores
// - each interval expiry clears one store alternately, other one shown
// - peak taken of the smoothed signal, not of raw samples
// - auto clears when temperature passes low limit by 1 % or 2 degrees
`timescale 1ns/100ps
module phrf_top
  import phrf_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // raw intensity ratio or intensity in
  input  wire logic [15:0] i_raw,
  input  wire logic        i_raw_valid,
  output logic             o_raw_ready,
  // corrected value out
  output logic      [15:0] o_corr,
  output logic             o_corr_valid,
  // temperature stream, tenths of a degree
  input  wire logic [15:0] i_temp,
  input  wire logic        i_low_signal,
  output logic             o_sample_req,
  output logic      [15:0] o_temp,
  output logic             o_temp_valid,
  output logic             o_peak_active,
  // relay contact pin
  input  wire logic        i_contact_closed
);
  phrf_div_if div ();

  logic        one_colour;
  logic [15:0] slope;
  logic [15:0] trans;
  logic [2:0]  resp_sel;
  logic [3:0]  clr_sel;
  logic [15:0] low_lim;
  logic        wr_reject;
  logic        contact;
  logic        contact_q;
  logic        contact_edge;
  logic [SAMPLE_CNT_W-1:0] tick_cnt;
  logic        tick;
  logic        tick_d;
  logic        tick_dd;
  logic [23:0] acc;
  logic [15:0] filt;
  logic [15:0] peak0;
  logic [15:0] peak1;
  logic        show_sel;
  logic [11:0] ivl_cnt;
  logic        ivl_exp;
  logic        armed;
  logic        auto_clr;
  logic [16:0] auto_thr;
  logic [16:0] pct;
  logic        is_ivl;
  logic [15:0] next_temp;

  phrf_sync u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_contact_closed),
    .o_level  (contact)
  );

  phrf_div u_div (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .div      (div.unit)
  );

  // register writes with range check
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      one_colour <= 1'b0;
      slope      <= SLOPE_RST;
      trans      <= TRANS_RST;
      resp_sel   <= RESP_MIN;
      clr_sel    <= CLR_OFF;
      low_lim    <= LOWLIM_RST;
      wr_reject  <= 1'b0;
    end else if (i_wr) begin
      wr_reject <= 1'b0;
      unique case (i_addr)
        REG_CTRL: begin
          one_colour <= i_wdata[0];
        end
        REG_SLOPE: begin
          if (i_wdata >= SLOPE_MIN && i_wdata <= SLOPE_MAX) begin
            slope <= i_wdata;
          end else begin
            wr_reject <= 1'b1;
          end
        end
        REG_TRANS: begin
          if (i_wdata >= TRANS_MIN && i_wdata <= TRANS_MAX) begin
            trans <= i_wdata;
          end else begin
            wr_reject <= 1'b1;
          end
        end
        REG_RESP: begin
          if (i_wdata <= {13'h0000, RESP_10S}) begin
            resp_sel <= i_wdata[2:0];
          end else begin
            wr_reject <= 1'b1;
          end
        end
        REG_CLEAR: begin
          if (i_wdata <= {12'h000, CLR_HOLD}) begin
            clr_sel <= i_wdata[3:0];
          end else begin
            wr_reject <= 1'b1;
          end
        end
        REG_LOWLIM: begin
          low_lim <= i_wdata;
        end
        default: begin
          wr_reject <= 1'b0;
        end
      endcase
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_CTRL:   o_rdata <= {15'h0000, one_colour};
        REG_SLOPE:  o_rdata <= slope;
        REG_TRANS:  o_rdata <= trans;
        REG_RESP:   o_rdata <= {13'h0000, resp_sel};
        REG_CLEAR:  o_rdata <= {12'h000, clr_sel};
        REG_LOWLIM: o_rdata <= low_lim;
        REG_STATUS: o_rdata <= {12'h000, show_sel, o_peak_active,
                                contact, wr_reject};
        REG_TEMP:   o_rdata <= o_temp;
        REG_PEAK0:  o_rdata <= peak0;
        REG_PEAK1:  o_rdata <= peak1;
        default:    o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ratio over slope, or intensity over transmittance
  assign div.req = i_raw_valid && o_raw_ready;
  assign div.num = {16'h0000, i_raw} * SCALE_MILLI;
  assign div.den = one_colour ? trans : slope;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_corr       <= 16'h0000;
      o_corr_valid <= 1'b0;
      o_raw_ready  <= 1'b0;
    end else begin
      o_corr_valid <= div.done;
      o_raw_ready  <= !div.busy && !(i_raw_valid && o_raw_ready);
      if (div.done) begin
        o_corr <= div.quo;
      end
    end
  end

  // sample tick every 10 ms
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (tick_cnt == SAMPLE_CNT_W'(SAMPLE_CYC - 1)) begin
        tick_cnt <= '0;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  // first-order smoothing, run on every sample tick
  logic [3:0]         shift;
  logic signed [24:0] diff;
  assign shift = (resp_sel == RESP_MIN && i_low_signal) ? 4'h1
                 : resp_shift(resp_sel);
  assign diff  = $signed({1'b0, i_temp, 8'h00}) - $signed({1'b0, acc});

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc <= 24'h000000;
    end else if (tick) begin
      if (shift == 4'h0) begin
        acc <= {i_temp, 8'h00};
      end else begin
        acc <= acc + 24'(diff >>> shift);
      end
    end
  end
  assign filt = acc[23:FRAC_W];

  // contact edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      contact_q <= 1'b0;
      tick_d    <= 1'b0;
      tick_dd   <= 1'b0;
    end else begin
      contact_q <= contact;
      tick_d    <= tick;
      tick_dd   <= tick_d;
    end
  end
  assign contact_edge = contact && !contact_q;

  // interval timing in sample periods
  assign is_ivl  = (clr_sel >= CLR_IVL_LO) && (clr_sel <= CLR_IVL_HI);
  assign ivl_exp = tick_d && (ivl_cnt >= ivl_ticks(clr_sel) - 12'h001);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ivl_cnt <= 12'h000;
    end else if (!is_ivl || ivl_exp) begin
      ivl_cnt <= 12'h000;
    end else if (tick_d) begin
      ivl_cnt <= ivl_cnt + 12'h001;
    end
  end

  // auto clear on positive pass of low limit plus margin
  assign pct      = {1'b0, low_lim} / AUTO_PCT_DIV;
  assign auto_thr = {1'b0, low_lim}
                    + ((pct > AUTO_MIN_RISE) ? pct : AUTO_MIN_RISE);
  assign auto_clr = tick_d && armed && ({1'b0, filt} > auto_thr);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed <= 1'b0;
    end else if (tick_d) begin
      if (filt <= low_lim) begin
        armed <= 1'b1;
      end else if (auto_clr) begin
        armed <= 1'b0;
      end
    end
  end

  // peak stores fed by the smoothed value
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      peak0    <= 16'h0000;
      peak1    <= 16'h0000;
      show_sel <= 1'b0;
    end else if (is_ivl) begin
      if (tick_d) begin
        if (ivl_exp && !show_sel) begin
          peak0 <= filt;
        end else if (filt > peak0) begin
          peak0 <= filt;
        end
        if (ivl_exp && show_sel) begin
          peak1 <= filt;
        end else if (filt > peak1) begin
          peak1 <= filt;
        end
        if (ivl_exp) begin
          show_sel <= !show_sel;
        end
      end
    end else if (clr_sel == CLR_EXTERN || clr_sel == CLR_AUTO) begin
      show_sel <= 1'b1;
      peak1    <= 16'h0000;
      if (clr_sel == CLR_EXTERN && contact_edge) begin
        peak0 <= 16'h0000;
      end else if (auto_clr) begin
        peak0 <= filt;
      end else if (tick_d && filt > peak0) begin
        peak0 <= filt;
      end
    end else begin
      peak0    <= filt;
      peak1    <= filt;
      show_sel <= 1'b0;
    end
  end

  // shown value per clear setting
  always_comb begin
    unique case (1'b1)
      is_ivl:                 next_temp = show_sel ? peak1 : peak0;
      clr_sel == CLR_EXTERN,
      clr_sel == CLR_AUTO:    next_temp = peak0;
      clr_sel == CLR_HOLD:    next_temp = contact ? o_temp : filt;
      default:                next_temp = filt;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_temp        <= 16'h0000;
      o_temp_valid  <= 1'b0;
      o_sample_req  <= 1'b0;
      o_peak_active <= 1'b0;
    end else begin
      o_sample_req  <= tick;
      o_temp_valid  <= tick_dd;
      o_peak_active <= (clr_sel != CLR_OFF) && (clr_sel != CLR_HOLD);
      // shown once the peak stores hold this sample
      if (tick_dd) begin
        o_temp <= next_temp;
      end
    end
  end
endmodule

// File: phrf_contact_model.sv
`timescale 1ns/100ps
module phrf_contact_model (
  // clock
  input  wire logic i_clk,
  // closure request, held closure and relay contact
  input  wire logic i_press,
  input  wire logic i_hold,
  output logic      o_contact_closed
);
  logic pulse;

  // one clean six-cycle closure per request
  initial pulse = 1'b0;
  always @(posedge i_clk) begin
    if (i_press) begin
      pulse <= 1'b1;
      repeat (6) @(posedge i_clk);
      pulse <= 1'b0;
    end
  end
  assign o_contact_closed = pulse | i_hold;
endmodule

// File: phrf_top_monitor.sv
`timescale 1ns/100ps
module phrf_top_monitor
  import phrf_pkg::*;
#(
  parameter int SAMPLE_CYC = 20
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // register writes
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  // corrector
  input  wire logic        i_raw_valid,
  input  wire logic        o_raw_ready,
  input  wire logic        o_corr_valid,
  // temperature stream
  input  wire logic        o_sample_req,
  input  wire logic [15:0] o_temp,
  input  wire logic        o_temp_valid,
  input  wire logic        o_peak_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // cycles since the last sample request
  logic [31:0] gap;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap <= 32'h0000_0000;
    end else if (o_sample_req) begin
      gap <= 32'h0000_0001;
    end else if (gap != 32'h0000_0000) begin
      gap <= gap + 32'h0000_0001;
    end
  end
  AST_SAMPLE_PERIOD: assert property (
    o_sample_req && gap != 32'h0000_0000 |-> gap == 32'(SAMPLE_CYC))
    else $error("sample request period wrong");
  AST_SAMPLE_GAP: assert property (
    o_sample_req |=> !o_sample_req [*8])
    else $error("sample request too early");
  AST_TEMP_VALID: assert property (
    o_sample_req |=> ##1 o_temp_valid)
    else $error("temperature not refreshed");
  AST_TEMP_STABLE: assert property (
    !o_temp_valid |-> $stable(o_temp))
    else $error("temperature changed without valid");
  AST_CORR_LAT: assert property (
    i_raw_valid && o_raw_ready |-> ##34 o_corr_valid)
    else $error("corrected value late");
  AST_READY_LOW: assert property (
    i_raw_valid && o_raw_ready |=> !o_raw_ready [*8])
    else $error("raw taken while busy");
  AST_CORR_ONE: assert property (
    o_corr_valid |=> !o_corr_valid)
    else $error("corrected valid too long");
  AST_PEAK_ACTIVE: assert property (
    i_wr && i_addr == REG_CLEAR && i_wdata < 16'h000A |-> ##2
    o_peak_active == ($past(i_wdata[3:0], 2) != CLR_OFF &&
                      $past(i_wdata[3:0], 2) != CLR_HOLD))
    else $error("peak storage enable wrong");
endmodule

bind phrf_top phrf_top_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) phrf_top_monitor_i (
  .i_clk        (i_clk),
  .i_arst_n     (i_arst_n),
  .i_addr       (i_addr),
  .i_wdata      (i_wdata),
  .i_wr         (i_wr),
  .i_raw_valid  (i_raw_valid),
  .o_raw_ready  (o_raw_ready),
  .o_corr_valid (o_corr_valid),
  .o_sample_req (o_sample_req),
  .o_temp       (o_temp),
  .o_temp_valid (o_temp_valid),
  .o_peak_active(o_peak_active)
);

// File: phrf_bench.sv
`timescale 1ns/100ps
module phrf_bench
  import phrf_pkg::*;
;
  logic        i_clk, i_arst_n, i_wr, i_rd, i_raw_valid, i_low_signal;
  logic        o_raw_ready, o_corr_valid, o_sample_req, o_temp_valid;
  logic        o_peak_active, press, hold, contact, rd_q;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, i_raw, i_temp, o_rdata, o_corr, o_temp;
  logic [15:0] rq[$], cq[$], tq[$];
  logic [31:0] seed, div;
  int          n_errors, check_count;

  phrf_top #(.SAMPLE_CYC(20)) phrf_top_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_raw(i_raw), .i_raw_valid(i_raw_valid), .o_raw_ready(o_raw_ready),
    .o_corr(o_corr), .o_corr_valid(o_corr_valid), .i_temp(i_temp),
    .i_low_signal(i_low_signal), .o_sample_req(o_sample_req),
    .o_temp(o_temp), .o_temp_valid(o_temp_valid),
    .o_peak_active(o_peak_active), .i_contact_closed(contact));
  phrf_contact_model phrf_contact_model_i (
    .i_clk(i_clk), .i_press(press), .i_hold(hold),
    .o_contact_closed(contact));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // read notes its expected data, write ignores the note
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    if (!w) rq.push_back(d);
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, e);
    bus(1'b1, a, d);
    bus(1'b0, a, e);
  endtask

  task automatic corr(input logic [15:0] raw);
    logic [31:0] q;
    q = raw * SCALE_MILLI / div;
    cq.push_back(q > 32'h0000FFFF ? 16'hFFFF : q[15:0]);
    @(posedge i_clk);
    i_raw <= raw;
    i_raw_valid <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge i_clk);
      if (o_raw_ready === 1'b1) break;
    end
    i_raw_valid <= 1'b0;
    repeat (40) @(posedge i_clk);
  endtask

  task automatic wait_valid();
    for (int k = 0; k < 100; k++) begin
      @(posedge i_clk);
      if (o_temp_valid === 1'b1) break;
    end
  endtask

  // next sample takes x and should show e
  task automatic step(input logic [15:0] x, e, input logic p);
    wait_valid();
    i_temp <= x;
    press <= p;
    #1 tq.push_back(e);
    @(posedge i_clk);
    press <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (rd_q) check(o_rdata, rq.pop_front());
    if (o_corr_valid === 1'b1) check(o_corr, cq.pop_front());
    if (o_temp_valid === 1'b1 && tq.size() > 0)
      check(o_temp, tq.pop_front());
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    {i_arst_n, i_wr, i_rd, i_raw_valid, i_low_signal, press, hold, rd_q} = 8'h00;
    {i_addr, i_wdata, i_raw, i_temp} = 52'h0;
    n_errors = 0;
    check_count = 0;
    seed = 32'h0000E74C;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    wr_rd(REG_SLOPE, 16'h031F, SLOPE_RST);
    wr_rd(REG_SLOPE, SLOPE_MIN, SLOPE_MIN);
    wr_rd(REG_SLOPE, 16'h04B1, SLOPE_MIN);
    wr_rd(REG_SLOPE, SLOPE_MAX, SLOPE_MAX);
    wr_rd(REG_TRANS, 16'h0031, TRANS_RST);
    wr_rd(REG_TRANS, TRANS_MIN, TRANS_MIN);
    wr_rd(REG_TRANS, 16'h03E9, TRANS_MIN);
    wr_rd(REG_RESP, 16'h0007, 16'h0000);
    for (int i = 0; i < 7; i++) wr_rd(REG_RESP, 16'(i), 16'(i));
    for (int i = 0; i < 10; i++) wr_rd(REG_CLEAR, 16'(i), 16'(i));
    wr_rd(REG_CLEAR, 16'h000A, 16'h0009);
    bus(1'b0, 4'hF, 16'h0000);
    done("registers");
    div = 32'(SLOPE_MAX);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      corr(seed[15:0]);
    end
    bus(1'b1, REG_SLOPE, SLOPE_MIN);
    div = 32'(SLOPE_MIN);
    corr(16'hFFFF);
    bus(1'b1, REG_CTRL, 16'h0001);
    bus(1'b1, REG_TRANS, 16'h01F4);
    div = 32'h000001F4;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      corr(seed[15:0]);
    end
    bus(1'b1, REG_CTRL, 16'h0000);
    done("corrector");
    bus(1'b1, REG_RESP, 16'h0002);
    bus(1'b1, REG_CLEAR, {12'h000, CLR_EXTERN});
    step(16'h03E8, 16'h01F4, 1'b0);
    step(16'h03E8, 16'h02EE, 1'b0);
    step(16'h03E8, 16'h036B, 1'b0);
    step(16'h0000, 16'h036B, 1'b0);
    bus(1'b1, REG_RESP, {13'h0000, RESP_MIN});
    step(16'h00C8, 16'h00C8, 1'b1);
    step(16'h0064, 16'h00C8, 1'b0);
    step(16'h0032, 16'h0032, 1'b0);
    bus(1'b1, REG_CLEAR, {12'h000, CLR_OFF});
    step(16'h0000, 16'h0000, 1'b0);
    wait_valid();
    bus(1'b1, REG_CLEAR, 16'h0001);
    step(16'h0064, 16'h0064, 1'b0);
    step(16'h0032, 16'h0064, 1'b0);
    step(16'h001E, 16'h0032, 1'b0);
    step(16'h0050, 16'h0050, 1'b0);
    wait_valid();
    bus(1'b1, REG_LOWLIM, 16'h0064);
    bus(1'b1, REG_CLEAR, {12'h000, CLR_AUTO});
    step(16'h00C8, 16'h00C8, 1'b0);
    step(16'h0096, 16'h00C8, 1'b0);
    step(16'h0032, 16'h00C8, 1'b0);
    step(16'h0082, 16'h0082, 1'b0);
    bus(1'b0, REG_PEAK1, 16'h0000);
    wait_valid();
    bus(1'b1, REG_CLEAR, {12'h000, CLR_HOLD});
    step(16'h012C, 16'h012C, 1'b0);
    wait_valid();
    hold <= 1'b1;
    step(16'h0190, 16'h012C, 1'b0);
    step(16'h01F4, 16'h01F4, 1'b0);
    hold <= 1'b0;
    wait_valid();
    bus(1'b1, REG_CLEAR, {12'h000, CLR_OFF});
    i_low_signal <= 1'b1;
    step(16'h0064, 16'h012C, 1'b0);
    wait_valid();
    i_low_signal <= 1'b0;
    done("filter and peak");
    summarize();
  end
endmodule
